//--- rtl/usbbs_core.sv
// Notes on behaviour
// - DMA FIFO access is byte or word; a word moves two FIFO bytes.
// - OUT FIFO word read byte order follows the read little-endian bit.
// - IN FIFO word write byte order follows the write little-endian bit.
// - Both byte-order bits are global, shared by every endpoint.
// - Little endian both ways gives same byte sequence as byte transfers.
// - Bus reset sets its flag; if enabled also raises CPU USB pending.
// - After bus reset the device answers only address zero.
// - Bus reset clears function address and endpoint select.
// - Bus reset flushes all FIFOs; IN and OUT endpoint flags keep their value.
// - Bus reset sets all interrupt enables except frame-start and suspend.
// - 3 ms idle with suspend allowed sets suspend flag, enters suspend.
// - Suspend entry raises CPU USB pending only if suspend enable set.
// - Non-idle signalling in suspend sets resume flag; wakes system only if resume enable set.
// - Bus reset in suspend wakes system, sets reset flag not resume.
// - Resume is driven while wakeup bit is set; firmware holds 1-15 ms.
// - Writing address sets pending bit; cleared when new address applies.
// - ISO hold bit sends zero-length packets until first frame start.
// - Power bit 3 reads 1 while reset signalling is on the bus.
// - Suspended bit set on entry; cleared by common flag read or wakeup.
// - IN flag register: EP0 bit 0, EP1-5 bits 1-5, cleared on read.
// - Common flags: frame start 3, reset 2, resume 1, suspend 0, read-clear.
// - Common enables reset to frame 0, reset 1, resume 1, suspend 0.
`include "usbbs_consts.svh"
module usbbs_core
  import usbbs_pkg::*;
#(
  parameter int IDLE_CYCLES = `USBBS_IDLE_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        bus_reset_seen,
  input  wire logic        bus_active,
  input  wire logic        frame_start,
  input  wire logic        addr_apply,
  input  wire logic [5:0]  in_ep_event,
  input  wire logic [4:0]  out_ep_event,
  input  wire logic        dma_word_size,
  input  wire logic [15:0] out_fifo_word,
  output logic      [15:0] out_dma_word,
  input  wire logic [15:0] in_dma_word,
  output logic      [15:0] in_fifo_word,
  output logic      [6:0]  match_address,
  output logic      [3:0]  endpoint_select,
  output logic             fifo_flush,
  output logic             iso_hold_until_frame_start,
  output logic             drive_wakeup_signal,
  output logic             suspended,
  output logic             cpu_usb_pending,
  output logic             wake_request
);

  logic [6:0]   addr_q;
  logic         addr_pend_q;
  logic [6:0]   addr_live_q;
  logic         iso_wait_q;
  logic         resume_q;
  logic         susp_en_q;
  logic         susp_bit_q;
  logic [5:0]   in_flags_q;
  logic [4:0]   out_flags_q;
  logic [3:0]   com_flags_q;
  logic [5:0]   in_en_q;
  logic [4:0]   out_en_q;
  logic [3:0]   com_en_q;
  logic [3:0]   index_q;
  logic [1:0]   endian_q;
  logic         pend_q;
  logic [31:0]  idle_q;
  usbbs_state_t state_q;
  logic         wr_addr, wr_pow, wr_inen, wr_outen, wr_comen, wr_idx, wr_end;
  logic         rd_in, rd_out, rd_com;
  logic         idle_done, enter_susp, resume_evt;
  logic [3:0]   com_set;

  assign wr_addr  = reg_wr && reg_addr == `USBBS_OFS_FADDR;
  assign wr_pow   = reg_wr && reg_addr == `USBBS_OFS_POWER;
  assign wr_inen  = reg_wr && reg_addr == `USBBS_OFS_INEN;
  assign wr_outen = reg_wr && reg_addr == `USBBS_OFS_OUTEN;
  assign wr_comen = reg_wr && reg_addr == `USBBS_OFS_COMEN;
  assign wr_idx   = reg_wr && reg_addr == `USBBS_OFS_INDEX;
  assign wr_end   = reg_wr && reg_addr == `USBBS_OFS_ENDIAN;
  assign rd_in    = reg_rd && reg_addr == `USBBS_OFS_INFLAGS;
  assign rd_out   = reg_rd && reg_addr == `USBBS_OFS_OUTFLAGS;
  assign rd_com   = reg_rd && reg_addr == `USBBS_OFS_COMFLAGS;

  // Byte order swappers, one global setting each
  usbbs_swap u_rd_swap
  (
    .little_en (endian_q[0] || !dma_word_size),
    .word_in   (out_fifo_word),
    .word_out  (out_dma_word)
  );
  usbbs_swap u_wr_swap
  (
    .little_en (endian_q[1] || !dma_word_size),
    .word_in   (in_dma_word),
    .word_out  (in_fifo_word)
  );

  // Idle timer on the device clock
  always_ff @(posedge clk)
  begin
    if (!reset_n || !susp_en_q || bus_active || bus_reset_seen || resume_q || state_q == USBBS_SUSPENDED)
      idle_q <= '0;
    else if (!idle_done)
      idle_q <= idle_q + 32'h1;
  end
  assign idle_done  = idle_q == IDLE_CYCLES - 1;
  assign enter_susp = idle_done && susp_en_q && state_q == USBBS_ACTIVE;
  assign resume_evt = state_q == USBBS_SUSPENDED && bus_active && !bus_reset_seen;

  // Suspend state machine
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      state_q <= USBBS_ACTIVE;
    else
      case (state_q)
        USBBS_ACTIVE:
          if (enter_susp)
            state_q <= USBBS_SUSPENDED;
        USBBS_SUSPENDED:
          if (bus_active || bus_reset_seen || resume_q)
            state_q <= USBBS_ACTIVE;
        default:
          state_q <= USBBS_ACTIVE;
      endcase
  end

  // Common flag set terms
  always_comb
  begin
    com_set = 4'h0;
    com_set[`USBBS_COM_SOF]     = frame_start;
    com_set[`USBBS_COM_RST]     = bus_reset_seen;
    com_set[`USBBS_COM_RESUME]  = resume_evt;
    com_set[`USBBS_COM_SUSPEND] = enter_susp;
  end

  // Read-clear flag registers, set wins
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      in_flags_q  <= 6'h00;
      out_flags_q <= 5'h00;
      com_flags_q <= 4'h0;
    end
    else
    begin
      in_flags_q  <= (rd_in ? 6'h00 : in_flags_q) | in_ep_event;
      out_flags_q <= (rd_out ? 5'h00 : out_flags_q) | out_ep_event;
      com_flags_q <= (rd_com ? 4'h0 : com_flags_q) | com_set;
    end
  end

  // CPU pending flag from enabled events
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      pend_q <= 1'b0;
    else if (|(com_set & com_en_q) || |(in_ep_event & in_en_q) || |(out_ep_event & out_en_q))
      pend_q <= 1'b1;
    else if (rd_com || rd_in || rd_out)
      pend_q <= 1'b0;
  end

  // Enable registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      com_en_q <= `USBBS_COMEN_RESET;
      in_en_q  <= `USBBS_INEN_RESET;
      out_en_q <= `USBBS_OUTEN_RESET;
    end
    else if (bus_reset_seen)
    begin
      com_en_q <= {com_en_q[`USBBS_COM_SOF], 2'b11, com_en_q[`USBBS_COM_SUSPEND]};
      in_en_q  <= `USBBS_INEN_RESET;
      out_en_q <= `USBBS_OUTEN_RESET;
    end
    else
    begin
      if (wr_comen)
        com_en_q <= reg_wdata[3:0];
      if (wr_inen)
        in_en_q <= reg_wdata[5:0];
      if (wr_outen)
        out_en_q <= reg_wdata[5:1];
    end
  end

  // Function address with deferred update
  always_ff @(posedge clk)
  begin
    if (!reset_n || bus_reset_seen)
    begin
      addr_q      <= 7'h00;
      addr_live_q <= 7'h00;
      addr_pend_q <= 1'b0;
      index_q     <= 4'h0;
    end
    else
    begin
      if (wr_addr)
      begin
        addr_q      <= reg_wdata[6:0];
        addr_pend_q <= 1'b1;
      end
      else if (addr_apply && addr_pend_q)
      begin
        addr_live_q <= addr_q;
        addr_pend_q <= 1'b0;
      end
      if (wr_idx)
        index_q <= reg_wdata[3:0];
    end
  end

  // Power/control and byte order registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      iso_wait_q <= 1'b0;
      resume_q   <= 1'b0;
      susp_en_q  <= 1'b0;
      endian_q   <= 2'b00;
    end
    else
    begin
      if (wr_pow)
      begin
        iso_wait_q <= reg_wdata[`USBBS_POW_ISO_WAIT];
        resume_q   <= reg_wdata[`USBBS_POW_RESUME];
        susp_en_q  <= reg_wdata[`USBBS_POW_SUSP_EN];
      end
      if (wr_end)
        endian_q <= reg_wdata[1:0];
    end
  end

  // Suspended status bit
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      susp_bit_q <= 1'b0;
    else if (enter_susp)
      susp_bit_q <= 1'b1;
    else if (rd_com || resume_q)
      susp_bit_q <= 1'b0;
  end

  // Register read mux
  always_comb
  begin
    reg_rdata = 8'h00;
    case (reg_addr)
      `USBBS_OFS_FADDR:    reg_rdata = {addr_pend_q, addr_q};
      `USBBS_OFS_POWER:    reg_rdata = {iso_wait_q, 3'b000, bus_reset_seen, resume_q, susp_bit_q, susp_en_q};
      `USBBS_OFS_INFLAGS:  reg_rdata = {2'b00, in_flags_q};
      `USBBS_OFS_OUTFLAGS: reg_rdata = {2'b00, out_flags_q, 1'b0};
      `USBBS_OFS_COMFLAGS: reg_rdata = {4'h0, com_flags_q};
      `USBBS_OFS_INEN:     reg_rdata = {2'b00, in_en_q};
      `USBBS_OFS_OUTEN:    reg_rdata = {2'b00, out_en_q, 1'b0};
      `USBBS_OFS_COMEN:    reg_rdata = {4'h0, com_en_q};
      `USBBS_OFS_INDEX:    reg_rdata = {4'h0, index_q};
      `USBBS_OFS_ENDIAN:   reg_rdata = {6'h00, endian_q};
      default:             reg_rdata = 8'h00;
    endcase
  end

  // Outputs
  assign match_address              = addr_live_q;
  assign endpoint_select            = index_q;
  assign fifo_flush                 = bus_reset_seen;
  assign iso_hold_until_frame_start = iso_wait_q;
  assign drive_wakeup_signal        = resume_q;
  assign suspended                  = state_q == USBBS_SUSPENDED;
  assign cpu_usb_pending            = pend_q;
  assign wake_request               = suspended &&
                                      (pend_q || bus_reset_seen || (bus_active && com_en_q[`USBBS_COM_RESUME]));

  // Checks
  a_reset_flag: assert property (@(posedge clk) disable iff (!reset_n)
    bus_reset_seen |=> com_flags_q[`USBBS_COM_RST]) else $error("reset flag not set");
  a_addr_clear: assert property (@(posedge clk) disable iff (!reset_n)
    bus_reset_seen |=> addr_live_q == 7'h00 && index_q == 4'h0) else $error("address not cleared");
  a_en_restore: assert property (@(posedge clk) disable iff (!reset_n)
    bus_reset_seen |=> com_en_q[2:1] == 2'b11 && $stable(com_en_q[3])) else $error("enables wrong");
  a_susp_entry: assert property (@(posedge clk) disable iff (!reset_n)
    enter_susp |=> state_q == USBBS_SUSPENDED && susp_bit_q) else $error("no suspend");
  a_susp_pend: assert property (@(posedge clk) disable iff (!reset_n)
    enter_susp && com_en_q[0] |=> pend_q) else $error("suspend pending missing");
  a_resume_flag: assert property (@(posedge clk) disable iff (!reset_n)
    resume_evt |=> com_flags_q[1] && state_q == USBBS_ACTIVE) else $error("resume missing");
  a_addr_pend: assert property (@(posedge clk) disable iff (!reset_n)
    wr_addr && !bus_reset_seen |=> addr_pend_q) else $error("pending not set");
  a_inflag_clr: assert property (@(posedge clk) disable iff (!reset_n)
    rd_in && in_ep_event == 6'h00 |=> in_flags_q == 6'h00) else $error("in flags kept");
  a_swap_big: assert property (@(posedge clk)
    dma_word_size && !endian_q[0] |-> out_dma_word == {out_fifo_word[7:0], out_fifo_word[15:8]})
    else $error("read order wrong");
  c_bus_reset: cover property (@(posedge clk) bus_reset_seen);
  c_suspend:   cover property (@(posedge clk) enter_susp);
  c_resume:    cover property (@(posedge clk) resume_evt);

endmodule // usbbs_core

//--- rtl/usbbs_consts.svh
`ifndef USBBS_CONSTS_SVH
`define USBBS_CONSTS_SVH

// Register offsets in the USB register window
`define USBBS_OFS_FADDR      16'hDE00
`define USBBS_OFS_POWER      16'hDE01
`define USBBS_OFS_INFLAGS    16'hDE02
`define USBBS_OFS_OUTFLAGS   16'hDE04
`define USBBS_OFS_COMFLAGS   16'hDE06
`define USBBS_OFS_INEN       16'hDE07
`define USBBS_OFS_OUTEN      16'hDE09
`define USBBS_OFS_COMEN      16'hDE0B
`define USBBS_OFS_INDEX      16'hDE0E
`define USBBS_OFS_ENDIAN     16'hDE20

// Power/control field positions
`define USBBS_POW_ISO_WAIT   7
`define USBBS_POW_RST        3
`define USBBS_POW_RESUME     2
`define USBBS_POW_SUSPENDED  1
`define USBBS_POW_SUSP_EN    0

// Common flag and enable field positions
`define USBBS_COM_SOF        3
`define USBBS_COM_RST        2
`define USBBS_COM_RESUME     1
`define USBBS_COM_SUSPEND    0

// Address register pending bit
`define USBBS_ADDR_PEND      7

// Reset values of the enable registers
`define USBBS_COMEN_RESET    4'h6
`define USBBS_INEN_RESET     6'h3F
`define USBBS_OUTEN_RESET    5'h1F

// Idle time before suspend
`define USBBS_IDLE_US        3000
`define USBBS_CLK_MHZ        100
`define USBBS_IDLE_CYCLES    (`USBBS_IDLE_US * `USBBS_CLK_MHZ)

`endif

//--- rtl/usbbs_pkg.sv
package usbbs_pkg;
  // Bus state as seen by the suspend logic
  typedef enum logic [1:0] {
    USBBS_ACTIVE,
    USBBS_SUSPENDED
  } usbbs_state_t;
endpackage

//--- rtl/usbbs_swap.sv
// Byte order of one 16-bit FIFO word
module usbbs_swap
  import usbbs_pkg::*;
(
  input  wire logic        little_en,
  input  wire logic [15:0] word_in,
  output logic      [15:0] word_out
);

  // Big endian: first FIFO byte is the high byte
  always_comb
  begin
    if (little_en)
      word_out = word_in;
    else
      word_out = {word_in[7:0], word_in[15:8]};
  end

endmodule // usbbs_swap

//--- sim/usbbs_host.sv
// Host or hub side of the bus, idle between transfers
module usbbs_host
(
  input  wire logic clk,
  output logic      bus_reset_seen,
  output logic      bus_active,
  output logic      frame_start
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idle at time zero
  initial
  begin
    bus_reset_seen = 1'b0;
    bus_active = 1'b0;
    frame_start = 1'b0;
  end

  // Reset signalling held for n cycles
  task automatic send_reset(input int n);
    @(negedge clk);
    bus_reset_seen = 1'b1;
    repeat (n) @(negedge clk);
    bus_reset_seen = 1'b0;
  endtask

  // Non-idle signalling, then back to idle
  task automatic send_activity(input int n);
    @(negedge clk);
    bus_active = 1'b1;
    repeat (n) @(negedge clk);
    bus_active = 1'b0;
  endtask

  // One frame-start token
  task automatic send_sof;
    @(negedge clk);
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
  endtask
endmodule // usbbs_host

//--- sim/tb_usb_bus_state_and_wakeup.sv
`include "usbbs_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_usb_bus_state_and_wakeup;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset_n, reg_wr, reg_rd, addr_apply, dma_word_size;
  logic [15:0] reg_addr, out_fifo_word, in_dma_word, out_dma_word, in_fifo_word;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        bus_reset_seen, bus_active, frame_start, fifo_flush, iso_hold;
  logic [5:0]  in_ep_event;
  logic [4:0]  out_ep_event;
  logic [6:0]  match_address;
  logic [3:0]  endpoint_select;
  logic        wakeup, suspended, cpu_usb_pending, wake_req;
  int          err_total, compares, cycles;

  usbbs_core #(.IDLE_CYCLES(20)) dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bus_reset_seen(bus_reset_seen), .bus_active(bus_active), .frame_start(frame_start),
    .addr_apply(addr_apply), .in_ep_event(in_ep_event), .out_ep_event(out_ep_event),
    .dma_word_size(dma_word_size), .out_fifo_word(out_fifo_word), .out_dma_word(out_dma_word),
    .in_dma_word(in_dma_word), .in_fifo_word(in_fifo_word), .match_address(match_address),
    .endpoint_select(endpoint_select), .fifo_flush(fifo_flush),
    .iso_hold_until_frame_start(iso_hold), .drive_wakeup_signal(wakeup),
    .suspended(suspended), .cpu_usb_pending(cpu_usb_pending), .wake_request(wake_req));

  usbbs_host host_u (.clk(clk), .bus_reset_seen(bus_reset_seen), .bus_active(bus_active),
    .frame_start(frame_start));

  // Clock source
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      stop_test;
    end
  end

  // Counts and verdict
  task automatic stop_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s done, err_total=%0d", s, err_total);
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // One-cycle read strobe, data checked in the strobe cycle
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    #1 `CHK(reg_rdata, e)
    @(negedge clk);
    reg_rd = 1'b0;
  endtask

  // Main sequence
  initial
  begin
    {reg_wr, reg_rd, addr_apply, dma_word_size} = 4'h0;
    {reg_addr, out_fifo_word, in_dma_word, reg_wdata} = 56'h0;
    {in_ep_event, out_ep_event} = 11'h0;
    reset_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    rd(`USBBS_OFS_COMEN, 8'h06);
    rd(`USBBS_OFS_POWER, 8'h00);
    rd(16'hDE3F, 8'h00);
    done("reset");
    wr(`USBBS_OFS_FADDR, 8'h05);
    rd(`USBBS_OFS_FADDR, 8'h85);
    @(negedge clk);
    addr_apply = 1'b1;
    @(negedge clk);
    addr_apply = 1'b0;
    @(negedge clk);
    `CHK(match_address, 7'h05)
    rd(`USBBS_OFS_FADDR, 8'h05);
    done("address");
    dma_word_size = 1'b1;
    out_fifo_word = 16'hA15C;
    in_dma_word = 16'h3C96;
    for (int i = 0; i < 4; i++)
    begin
      wr(`USBBS_OFS_ENDIAN, 8'(i));
      #1 `CHK(out_dma_word, i[0] ? 16'hA15C : 16'h5CA1)
      `CHK(in_fifo_word, i[1] ? 16'h3C96 : 16'h963C)
    end
    wr(`USBBS_OFS_ENDIAN, 8'h00);
    dma_word_size = 1'b0;
    #1 `CHK(out_dma_word, 16'hA15C)
    `CHK(in_fifo_word, 16'h3C96)
    done("byte order");
    @(negedge clk);
    in_ep_event = 6'h3F;
    out_ep_event = 5'h1F;
    @(negedge clk);
    {in_ep_event, out_ep_event} = 11'h0;
    rd(`USBBS_OFS_INFLAGS, 8'h3F);
    rd(`USBBS_OFS_INFLAGS, 8'h00);
    rd(`USBBS_OFS_OUTFLAGS, 8'h3E);
    done("endpoint flags");
    wr(`USBBS_OFS_INDEX, 8'h03);
    wr(`USBBS_OFS_COMEN, 8'h09);
    fork
      host_u.send_reset(6);
      begin
        @(negedge clk);
        rd(`USBBS_OFS_POWER, 8'h08);
        `CHK(fifo_flush, 1'b1)
      end
    join
    @(negedge clk);
    `CHK(match_address, 7'h00)
    `CHK(endpoint_select, 4'h0)
    `CHK(cpu_usb_pending, 1'b1)
    rd(`USBBS_OFS_COMEN, 8'h0F);
    rd(`USBBS_OFS_FADDR, 8'h00);
    rd(`USBBS_OFS_COMFLAGS, 8'h04);
    done("bus reset");
    wr(`USBBS_OFS_COMEN, 8'h03);
    wr(`USBBS_OFS_POWER, 8'h01);
    repeat (10) @(negedge clk);
    `CHK(suspended, 1'b0)
    repeat (15) @(negedge clk);
    `CHK(suspended, 1'b1)
    `CHK(cpu_usb_pending, 1'b1)
    rd(`USBBS_OFS_POWER, 8'h03);
    rd(`USBBS_OFS_COMFLAGS, 8'h01);
    rd(`USBBS_OFS_POWER, 8'h01);
    `CHK(wake_req, 1'b0)
    fork
      host_u.send_activity(2);
      begin
        @(negedge clk);
        #1 `CHK(wake_req, 1'b1)
      end
    join
    rd(`USBBS_OFS_COMFLAGS, 8'h02);
    `CHK(suspended, 1'b0)
    repeat (25) @(negedge clk);
    `CHK(suspended, 1'b1)
    host_u.send_reset(3);
    rd(`USBBS_OFS_COMFLAGS, 8'h05);
    repeat (5) @(negedge clk);
    done("suspend");
    repeat (25) @(negedge clk);
    wr(`USBBS_OFS_POWER, 8'h05);
    `CHK(wakeup, 1'b1)
    rd(`USBBS_OFS_POWER, 8'h05);
    repeat (20) @(negedge clk);
    wr(`USBBS_OFS_POWER, 8'h80);
    `CHK(wakeup, 1'b0)
    `CHK(iso_hold, 1'b1)
    host_u.send_sof;
    rd(`USBBS_OFS_COMFLAGS, 8'h09);
    wr(`USBBS_OFS_POWER, 8'h00);
    done("wakeup");
    stop_test;
  end
endmodule // tb_usb_bus_state_and_wakeup
